/* File: src/decrement_file_op_exec_top.sv */
// AXI4-Lite reachable core slice that runs the decrement-register instruction
`timescale 1ns/1ps
`include "decrement_file_op_exec_defs.svh"
module decrement_file_op_exec_top
    import decrement_file_op_exec_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [31:0] awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic      [1:0]  bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [31:0] araddr,
    input  wire logic [2:0]  arprot,
    input  wire logic        arvalid,
    output logic             arready,
    output logic      [31:0] rdata,
    output logic      [1:0]  rresp,
    output logic             rvalid,
    input  wire logic        rready
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic reg_sel_t decode_sel(input logic [31:0] addr);
        if (addr == `OFS_CTRL) begin
            return SEL_CTRL;
        end else if (addr == `OFS_INSTR) begin
            return SEL_INSTR;
        end else if (addr == `OFS_BANK) begin
            return SEL_BANK;
        end else if (addr == `OFS_WREG) begin
            return SEL_WREG;
        end else if (addr == `OFS_STATUS) begin
            return SEL_STATUS;
        end else if (addr == `OFS_STATE) begin
            return SEL_STATE;
        end else if (addr == `OFS_MEM_ADDR) begin
            return SEL_MEM_ADDR;
        end else if (addr == `OFS_MEM_DATA) begin
            return SEL_MEM_DATA;
        end else if (addr == `OFS_INDEX_BASE) begin
            return SEL_INDEX_BASE;
        end else if (addr == `OFS_LAST_ADDR) begin
            return SEL_LAST_ADDR;
        end else begin
            return SEL_NONE;
        end
    endfunction

    function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State

    logic              aw_held_reg,    aw_held_next;
    logic [31:0]       aw_addr_reg,    aw_addr_next;
    logic              w_held_reg,     w_held_next;
    logic [31:0]       w_data_reg,     w_data_next;
    logic [3:0]        w_strb_reg,     w_strb_next;
    logic              bvalid_reg,     bvalid_next;
    logic [1:0]        bresp_reg,      bresp_next;
    logic              rvalid_reg,     rvalid_next;
    logic [31:0]       rdata_reg,      rdata_next;
    logic [1:0]        rresp_reg,      rresp_next;

    quarter_t          state_reg,      state_next;
    logic              ext_en_reg,     ext_en_next;
    logic [15:0]       instr_reg,      instr_next;
    logic [3:0]        bank_reg,       bank_next;
    logic [7:0]        wreg_reg,       wreg_next;
    logic [7:0]        status_reg,     status_next;
    logic [11:0]       mem_addr_reg,   mem_addr_next;
    logic [11:0]       index_base_reg, index_base_next;
    logic              legal_reg,      legal_next;
    logic              illegal_reg,    illegal_next;
    logic              dest_reg,       dest_next;
    logic              acc_reg,        acc_next;
    logic [7:0]        f_reg,          f_next;
    logic [7:0]        operand_reg,    operand_next;
    logic [7:0]        result_reg,     result_next;
    logic [7:0]        flags_reg,      flags_next;
    logic [11:0]       last_addr_reg,  last_addr_next;
    logic              indexed_reg,    indexed_next;

    logic [7:0]        mem [0:4095];
    logic              mem_we;
    logic [11:0]       mem_waddr;
    logic [7:0]        mem_wdata;

    logic              do_write;
    reg_sel_t          wsel;
    reg_sel_t          rsel;
    logic              start_req;
    logic [31:0]       wmerged;
    logic [7:0]        alu_result;
    logic [7:0]        alu_flags;
    logic [31:0]       rd_value;

    operand_if oper ();

    assign oper.f          = f_reg;
    assign oper.a          = acc_reg;
    assign oper.ext_en     = ext_en_reg;
    assign oper.bank       = bank_reg;
    assign oper.index_base = index_base_reg;

    operand_address_unit u_addr (
        .oper (oper.resolver)
    );

    decrement_alu u_alu (
        .operand (operand_reg),
        .result  (alu_result),
        .flags   (alu_flags)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave

    assign awready = !aw_held_reg;
    assign wready  = !w_held_reg;
    assign arready = !rvalid_reg;
    assign bvalid  = bvalid_reg;
    assign bresp   = bresp_reg;
    assign rvalid  = rvalid_reg;
    assign rdata   = rdata_reg;
    assign rresp   = rresp_reg;

    // Writes wait while an instruction runs so memory and flags see one writer
    assign do_write  = aw_held_reg && w_held_reg && !bvalid_reg && (state_reg == EXEC_IDLE);
    assign wsel      = decode_sel(aw_addr_reg);
    assign rsel      = decode_sel(araddr);
    assign wmerged   = merge_strb(`RST_DATA, w_data_reg, w_strb_reg);
    assign start_req = do_write && (wsel == SEL_CTRL) && w_strb_reg[0] && w_data_reg[`CTRL_START];

    always_comb begin
        rd_value = `RST_DATA;
        if (rsel == SEL_CTRL) begin
            rd_value[`CTRL_EXT] = ext_en_reg;
        end else if (rsel == SEL_INSTR) begin
            rd_value[15:0] = instr_reg;
        end else if (rsel == SEL_BANK) begin
            rd_value[3:0] = bank_reg;
        end else if (rsel == SEL_WREG) begin
            rd_value[7:0] = wreg_reg;
        end else if (rsel == SEL_STATUS) begin
            rd_value[7:0] = status_reg;
        end else if (rsel == SEL_STATE) begin
            rd_value[`STATE_BUSY]                  = (state_reg != EXEC_IDLE);
            rd_value[`STATE_ILLEGAL]               = illegal_reg;
            rd_value[`STATE_INDEXED]               = indexed_reg;
            rd_value[`STATE_PH_HI:`STATE_PH_LO]    = state_reg;
        end else if (rsel == SEL_MEM_ADDR) begin
            rd_value[11:0] = mem_addr_reg;
        end else if (rsel == SEL_MEM_DATA) begin
            rd_value[7:0] = mem[mem_addr_reg];
        end else if (rsel == SEL_INDEX_BASE) begin
            rd_value[11:0] = index_base_reg;
        end else if (rsel == SEL_LAST_ADDR) begin
            rd_value[11:0] = last_addr_reg;
        end
    end

    always_comb begin
        aw_held_next = aw_held_reg;
        aw_addr_next = aw_addr_reg;
        w_held_next  = w_held_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        if (awvalid && awready) begin
            aw_held_next = 1'b1;
            aw_addr_next = awaddr;
        end
        if (wvalid && wready) begin
            w_held_next = 1'b1;
            w_data_next = wdata;
            w_strb_next = wstrb;
        end
        if (bvalid_reg && bready) begin
            bvalid_next = 1'b0;
        end
        if (do_write) begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = (wsel == SEL_NONE) ? `RESP_DECERR : `RESP_OKAY;
        end
        if (rvalid_reg && rready) begin
            rvalid_next = 1'b0;
        end
        if (arvalid && arready) begin
            rvalid_next = 1'b1;
            rdata_next  = rd_value;
            rresp_next  = (rsel == SEL_NONE) ? `RESP_DECERR : `RESP_OKAY;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Instruction cycle: one start makes four quarters and back to idle

    always_comb begin
        state_next      = state_reg;
        ext_en_next     = ext_en_reg;
        instr_next      = instr_reg;
        bank_next       = bank_reg;
        wreg_next       = wreg_reg;
        status_next     = status_reg;
        mem_addr_next   = mem_addr_reg;
        index_base_next = index_base_reg;
        legal_next      = legal_reg;
        illegal_next    = illegal_reg;
        dest_next       = dest_reg;
        acc_next        = acc_reg;
        f_next          = f_reg;
        operand_next    = operand_reg;
        result_next     = result_reg;
        flags_next      = flags_reg;
        last_addr_next  = last_addr_reg;
        indexed_next    = indexed_reg;
        mem_we          = 1'b0;
        mem_waddr       = mem_addr_reg;
        mem_wdata       = wmerged[7:0];
        case (state_reg)
            EXEC_IDLE: begin
                if (start_req) begin
                    state_next   = EXEC_Q1;
                    illegal_next = 1'b0;
                end
            end
            EXEC_Q1: begin
                legal_next = (instr_reg[`OPC_HI:`OPC_LO] == `OPC_DECREMENT_FILE_OP);
                dest_next  = instr_reg[`OPC_D_BIT];
                acc_next   = instr_reg[`OPC_A_BIT];
                f_next     = instr_reg[`OPC_F_HI:0];
                state_next = EXEC_Q2;
            end
            EXEC_Q2: begin
                operand_next   = mem[oper.addr];
                last_addr_next = oper.addr;
                indexed_next   = oper.indexed;
                state_next     = EXEC_Q3;
            end
            EXEC_Q3: begin
                result_next = alu_result;
                flags_next  = alu_flags;
                state_next  = EXEC_Q4;
            end
            EXEC_Q4: begin
                if (legal_reg) begin
                    if (dest_reg) begin
                        mem_we    = 1'b1;
                        mem_waddr = last_addr_reg;
                        mem_wdata = result_reg;
                    end else begin
                        wreg_next = result_reg;
                    end
                    status_next = (status_reg & ~`ST_FLAG_MASK) | (flags_reg & `ST_FLAG_MASK);
                end else begin
                    // Unknown opcode completes the cycle, leaves memory, wreg and status alone and sets the illegal flag
                    illegal_next = 1'b1;
                end
                state_next = EXEC_IDLE;
            end
            default: begin
                state_next = EXEC_IDLE;
            end
        endcase
        if (do_write) begin
            if (wsel == SEL_CTRL) begin
                if (w_strb_reg[0]) begin
                    ext_en_next = w_data_reg[`CTRL_EXT];
                end
            end else if (wsel == SEL_INSTR) begin
                instr_next = 16'(merge_strb({16'h0000, instr_reg}, w_data_reg, w_strb_reg));
            end else if (wsel == SEL_BANK) begin
                if (w_strb_reg[0]) begin
                    bank_next = w_data_reg[3:0];
                end
            end else if (wsel == SEL_WREG) begin
                if (w_strb_reg[0]) begin
                    wreg_next = w_data_reg[7:0];
                end
            end else if (wsel == SEL_STATUS) begin
                if (w_strb_reg[0]) begin
                    status_next = w_data_reg[7:0];
                end
            end else if (wsel == SEL_MEM_ADDR) begin
                mem_addr_next = 12'(merge_strb({20'h0_0000, mem_addr_reg}, w_data_reg, w_strb_reg));
            end else if (wsel == SEL_MEM_DATA) begin
                mem_we = w_strb_reg[0];
            end else if (wsel == SEL_INDEX_BASE) begin
                index_base_next = 12'(merge_strb({20'h0_0000, index_base_reg}, w_data_reg, w_strb_reg));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    // Data store is not reset; software initialises what it uses
    always_ff @(posedge aclk) begin
        if (ce && mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg    <= 1'b0;
            aw_addr_reg    <= `RST_DATA;
            w_held_reg     <= 1'b0;
            w_data_reg     <= `RST_DATA;
            w_strb_reg     <= 4'h0;
            bvalid_reg     <= 1'b0;
            bresp_reg      <= `RESP_OKAY;
            rvalid_reg     <= 1'b0;
            rdata_reg      <= `RST_DATA;
            rresp_reg      <= `RESP_OKAY;
            state_reg      <= EXEC_IDLE;
            ext_en_reg     <= 1'b0;
            instr_reg      <= `RST_INSTR;
            bank_reg       <= 4'h0;
            wreg_reg       <= `RST_BYTE;
            status_reg     <= `RST_BYTE;
            mem_addr_reg   <= `RST_ADDR;
            index_base_reg <= `RST_ADDR;
            legal_reg      <= 1'b0;
            illegal_reg    <= 1'b0;
            dest_reg       <= 1'b1;
            acc_reg        <= 1'b1;
            f_reg          <= `RST_BYTE;
            operand_reg    <= `RST_BYTE;
            result_reg     <= `RST_BYTE;
            flags_reg      <= `RST_BYTE;
            last_addr_reg  <= `RST_ADDR;
            indexed_reg    <= 1'b0;
        end else if (ce) begin
            aw_held_reg    <= aw_held_next;
            aw_addr_reg    <= aw_addr_next;
            w_held_reg     <= w_held_next;
            w_data_reg     <= w_data_next;
            w_strb_reg     <= w_strb_next;
            bvalid_reg     <= bvalid_next;
            bresp_reg      <= bresp_next;
            rvalid_reg     <= rvalid_next;
            rdata_reg      <= rdata_next;
            rresp_reg      <= rresp_next;
            state_reg      <= state_next;
            ext_en_reg     <= ext_en_next;
            instr_reg      <= instr_next;
            bank_reg       <= bank_next;
            wreg_reg       <= wreg_next;
            status_reg     <= status_next;
            mem_addr_reg   <= mem_addr_next;
            index_base_reg <= index_base_next;
            legal_reg      <= legal_next;
            illegal_reg    <= illegal_next;
            dest_reg       <= dest_next;
            acc_reg        <= acc_next;
            f_reg          <= f_next;
            operand_reg    <= operand_next;
            result_reg     <= result_next;
            flags_reg      <= flags_next;
            last_addr_reg  <= last_addr_next;
            indexed_reg    <= indexed_next;
        end
    end

endmodule

/* File: src/decrement_file_op_exec_defs.svh */
// Constants for the decrement-register execution block
`ifndef DECREMENT_FILE_OP_EXEC_DEFS_SVH
`define DECREMENT_FILE_OP_EXEC_DEFS_SVH

// Register byte offsets
`define OFS_CTRL        32'h0000_0000
`define OFS_INSTR       32'h0000_0004
`define OFS_BANK        32'h0000_0008
`define OFS_WREG        32'h0000_000c
`define OFS_STATUS      32'h0000_0010
`define OFS_STATE       32'h0000_0014
`define OFS_MEM_ADDR    32'h0000_0018
`define OFS_MEM_DATA    32'h0000_001c
`define OFS_INDEX_BASE  32'h0000_0020
`define OFS_LAST_ADDR   32'h0000_0024

// Control and state bit positions
`define CTRL_START      0
`define CTRL_EXT        1
`define STATE_BUSY      0
`define STATE_ILLEGAL   1
`define STATE_INDEXED   2
`define STATE_PH_LO     4
`define STATE_PH_HI     6

// Opcode layout
`define OPC_HI          15
`define OPC_LO          10
`define OPC_DECREMENT_FILE_OP        6'h01
`define OPC_D_BIT       9
`define OPC_A_BIT       8
`define OPC_F_HI        7

// Status flag positions
`define ST_C            0
`define ST_DC           1
`define ST_Z            2
`define ST_OV           3
`define ST_N            4
`define ST_FLAG_MASK    8'h1f

// Address resolution and ALU constants
`define ACCESS_SPLIT    8'h60
`define ACCESS_LO_BANK  4'h0
`define ACCESS_HI_BANK  4'hf
`define INDEXED_MAX     8'h5f
`define ONE_BYTE        8'h01
`define ZERO_BYTE       8'h00
`define SIGN_MIN        8'h80
`define ZERO_NIB        4'h0

// Reset values
`define RST_BYTE        8'h00
`define RST_INSTR       16'h0000
`define RST_ADDR        12'h000
`define RST_DATA        32'h0000_0000

// Bus answers
`define RESP_OKAY       2'b00
`define RESP_DECERR     2'b11

`endif

/* File: src/decrement_file_op_exec_pkg.sv */
// Types shared by the decrement-register execution block
package decrement_file_op_exec_pkg;

    typedef enum logic [2:0] {
        EXEC_IDLE,
        EXEC_Q1,
        EXEC_Q2,
        EXEC_Q3,
        EXEC_Q4
    } quarter_t;

    typedef enum logic [3:0] {
        SEL_CTRL,
        SEL_INSTR,
        SEL_BANK,
        SEL_WREG,
        SEL_STATUS,
        SEL_STATE,
        SEL_MEM_ADDR,
        SEL_MEM_DATA,
        SEL_INDEX_BASE,
        SEL_LAST_ADDR,
        SEL_NONE
    } reg_sel_t;

endpackage

/* File: src/operand_if.sv */
// Operand fields and the resolved data-memory address
`timescale 1ns/1ps
interface operand_if;
    logic [7:0]  f;
    logic        a;
    logic        ext_en;
    logic [3:0]  bank;
    logic [11:0] index_base;
    logic [11:0] addr;
    logic        indexed;

    modport requester (output f, output a, output ext_en, output bank, output index_base,
                       input addr, input indexed);
    modport resolver  (input f, input a, input ext_en, input bank, input index_base,
                       output addr, output indexed);
endinterface

/* File: src/operand_address_unit.sv */
// Resolves the 8-bit operand address into a 12-bit data-memory address
`timescale 1ns/1ps
`include "decrement_file_op_exec_defs.svh"
module operand_address_unit
    import decrement_file_op_exec_pkg::*;
(
    operand_if.resolver oper
);
    always_comb begin
        oper.indexed = 1'b0;
        if (oper.ext_en && !oper.a && (oper.f <= `INDEXED_MAX)) begin
            // Offset from the index base; wraps inside the 4 KB space
            oper.addr    = 12'(oper.index_base + {`ZERO_NIB, oper.f});
            oper.indexed = 1'b1;
        end else if (!oper.a) begin
            if (oper.f < `ACCESS_SPLIT) begin
                oper.addr = {`ACCESS_LO_BANK, oper.f};
            end else begin
                oper.addr = {`ACCESS_HI_BANK, oper.f};
            end
        end else begin
            oper.addr = {oper.bank, oper.f};
        end
    end
endmodule

/* File: src/decrement_alu.sv */
// Subtract-one datapath with its five arithmetic flags
`timescale 1ns/1ps
`include "decrement_file_op_exec_defs.svh"
module decrement_alu
    import decrement_file_op_exec_pkg::*;
(
    input  wire logic [7:0] operand,
    output logic      [7:0] result,
    output logic      [7:0] flags
);
    always_comb begin
        result            = 8'(operand - `ONE_BYTE);
        flags             = `ZERO_BYTE;
        flags[`ST_C]      = (operand != `ZERO_BYTE);
        flags[`ST_DC]     = (operand[3:0] != `ZERO_NIB);
        flags[`ST_Z]      = (result == `ZERO_BYTE);
        flags[`ST_OV]     = (operand == `SIGN_MIN);
        flags[`ST_N]      = result[7];
    end
endmodule

/* File: dv/decrement_file_op_exec_chk.sv */
// Bus checks for the decrement-register block
`timescale 1ns/1ps
`include "decrement_file_op_exec_defs.svh"
module decrement_file_op_exec_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        ce,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic [1:0]  bresp,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [31:0] araddr,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire logic        rvalid,
    input wire logic        rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_take;
        awvalid && awready && wvalid && wready && ce;
    endsequence
    sequence rd_take;
        arvalid && arready && ce;
    endsequence
    // A run stalls a write by up to three cycles
    a_write_done: assert property (wr_take |-> ##[1:8] bvalid) else $error("write unanswered");
    a_read_turn: assert property (rd_take |=> rvalid) else $error("read unanswered");
    a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rdata lost");
    a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp lost");
    a_resp_cause: assert property ($rose(bvalid) |-> !$past(awready) && !$past(wready)) else $error("stray bvalid");
    a_read_block: assert property (rvalid |-> !arready) else $error("arready with rvalid");
    a_unmapped_read: assert property ((rd_take and (araddr > `OFS_LAST_ADDR)) |=> rresp == `RESP_DECERR)
        else $error("unmapped read accepted");
    a_reset_idle: assert property (disable iff (1'b0) !aresetn |=> !bvalid && !rvalid && arready && awready)
        else $error("bus busy in reset");
endmodule
bind decrement_file_op_exec_top decrement_file_op_exec_chk chk (.*);

/* File: dv/tb.sv */
// Self-checking bench for the decrement-register block
`timescale 1ns/1ps
`include "decrement_file_op_exec_defs.svh"
module tb;
    logic        aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [1:0]  bresp, rresp;
    logic [2:0]  awprot = 3'h0, arprot = 3'h0;
    logic [3:0]  wstrb = 4'hf;
    int          n_fail = 0, compares = 0;
    decrement_file_op_exec_top DUT (.*);
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////
    task automatic results;
        if (n_fail == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, e);
        compares++;
        if (g !== e) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
            n_fail++;
        end
    endtask
    task automatic wr(input logic [31:0] ad, dt, input logic [1:0] er = `RESP_OKAY);
        bit pa = 1, pw = 1;
        @(posedge aclk);
        awaddr <= ad;
        wdata <= dt;
        {awvalid, wvalid, bready} <= 3'h7;
        while (pa || pw) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            pa = pa && !awready;
            pw = pw && !wready;
        end
        while (!bvalid) @(posedge aclk);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [31:0] ad, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= ad;
        {arvalid, rready} <= 2'h3;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask
    task automatic rc(input logic [31:0] ad, e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(ad, d, r);
        chk({30'h0, r}, {30'h0, `RESP_OKAY});
        chk(d, e);
    endtask
    task automatic mset(input logic [11:0] a, input logic [7:0] v);
        wr(`OFS_MEM_ADDR, {20'h0, a});
        wr(`OFS_MEM_DATA, {24'h0, v});
    endtask
    task automatic mchk(input logic [11:0] a, input logic [7:0] v);
        wr(`OFS_MEM_ADDR, {20'h0, a});
        rc(`OFS_MEM_DATA, {24'h0, v});
    endtask
    // Two status polls must see busy gone: the run fits in four cycles
    task automatic run(input logic d, a, ext, input logic [7:0] f, input logic [5:0] opc = 6'h01);
        logic [31:0] s;
        logic [1:0]  r;
        int          n = 0;
        wr(`OFS_INSTR, {16'h0, opc, d, a, f});
        wr(`OFS_CTRL, {30'h0, ext, 1'b1});
        do begin
            rd(`OFS_STATE, s, r);
            n++;
        end while (s[0]);
        chk({31'h0, n <= 2}, 32'h1);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_bus;
        logic [31:0] d;
        logic [1:0]  r;
        rd(32'h0000_0028, d, r);
        chk({30'h0, r}, {30'h0, `RESP_DECERR});
        wr(32'h0000_0030, 32'h0000_00ff, `RESP_DECERR);
        ce <= 1'b0;
        repeat (3) @(posedge aclk);
        ce <= 1'b1;
        wr(`OFS_WREG, 32'h0000_00a5);
        rc(`OFS_WREG, 32'h0000_00a5);
    endtask
    task automatic t_flags;
        logic [7:0] op[4] = '{8'h00, 8'h01, 8'h80, 8'h11};
        logic [7:0] res[4] = '{8'hff, 8'h00, 8'h7f, 8'h10};
        logic [7:0] flg[4] = '{8'hf0, 8'he7, 8'he9, 8'he3};
        wr(`OFS_BANK, 32'h0000_0002);
        wr(`OFS_STATUS, 32'h0000_00ff);
        for (int i = 0; i < 4; i++) begin
            mset(12'h233, op[i]);
            run(1'b0, 1'b1, 1'b0, 8'h33);
            rc(`OFS_WREG, {24'h0, res[i]});
            rc(`OFS_STATUS, {24'h0, flg[i]});
            mchk(12'h233, op[i]);
        end
    endtask
    task automatic t_dest;
        logic [11:0] ad[2] = '{12'h010, 12'hf70};
        wr(`OFS_BANK, 32'h0000_0005);
        wr(`OFS_WREG, 32'h0000_00c3);
        for (int i = 0; i < 2; i++) begin
            mset(ad[i], 8'h5a);
            run(1'b1, 1'b0, 1'b0, ad[i][7:0]);
            mchk(ad[i], 8'h59);
            rc(`OFS_LAST_ADDR, {20'h0, ad[i]});
        end
        rc(`OFS_WREG, 32'h0000_00c3);
    endtask
    task automatic t_indexed;
        logic [11:0] ad[2] = '{12'h25f, 12'hf60};
        wr(`OFS_INDEX_BASE, 32'h0000_0200);
        for (int i = 0; i < 2; i++) begin
            mset(ad[i], 8'h42);
            run(1'b1, 1'b0, 1'b1, ad[i][7:0]);
            mchk(ad[i], 8'h41);
            rc(`OFS_STATE, {29'h0, !i[0], 2'h0});
        end
    endtask
    task automatic t_illegal;
        wr(`OFS_WREG, 32'h0000_003c);
        run(1'b0, 1'b1, 1'b0, 8'h33, 6'h02);
        rc(`OFS_STATE, 32'h0000_0002);
        rc(`OFS_WREG, 32'h0000_003c);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        ce = 1'b1;
        awaddr = 32'h0;
        wdata = 32'h0;
        araddr = 32'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_bus();
        t_flags();
        t_dest();
        t_indexed();
        t_illegal();
        results();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge aclk);
        n_fail++;
        results();
    end
endmodule
